/* File: logic/tp_drive_defs.svh */
// Constants for the totem-pole drive steering block
`ifndef TP_DRIVE_DEFS_SVH
`define TP_DRIVE_DEFS_SVH

// ==========================================================
// Timing
`define TP_CLK_PERIOD_NS 5
`define TP_OT_FILTER_NS 30000
`define TP_OV_FILTER_NS 30000
`define TP_OT_BLANK_NS 5000000
`define TP_POL_FILTER_NS 200000
`define TP_OT_FILTER_CYC (`TP_OT_FILTER_NS / `TP_CLK_PERIOD_NS)
`define TP_OV_FILTER_CYC (`TP_OV_FILTER_NS / `TP_CLK_PERIOD_NS)
`define TP_OT_BLANK_CYC (`TP_OT_BLANK_NS / `TP_CLK_PERIOD_NS)
`define TP_POL_FILTER_CYC (`TP_POL_FILTER_NS / `TP_CLK_PERIOD_NS)

// ==========================================================
// Counts
`define TP_VALID_NEEDED 3'h4
`define TP_SYNC_HOLD 1

`endif

/* File: logic/tp_drive_pkg.sv */
// Types shared by the totem-pole drive steering block
package tp_drive_pkg;

    // ==========================================================
    // Drive outputs to the half-bridge drivers
    typedef struct packed {
        logic fast_low_drive;
        logic fast_high_drive;
        logic slow_low_drive;
        logic slow_high_drive;
    } drive_t;

    // Status reported to the rest of the controller
    typedef struct packed {
        logic running;
        logic over_temp_fault;
        logic over_voltage_fault;
        logic line_freq_ok;
        logic polarity;
    } status_t;

    // Run sequencer, Gray along idle, armed, run
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARMED = 2'h1,
        ST_RUN = 2'h3
    } run_state_t;

endpackage : tp_drive_pkg

/* File: logic/level_filter.sv */
// Three-stage synchroniser followed by a hold-time glitch filter
`timescale 1ns/100ps
module level_filter #(
    parameter int HOLD = 1,
    parameter bit INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw,
    output logic filtered
);
    localparam int W = $clog2(HOLD + 1) + 1;
    localparam logic [W-1:0] HOLD_W = W'(HOLD);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
        logic [W-1:0] cnt;
    } filt_state_t;

    filt_state_t st;
    filt_state_t next_st;

    // ==========================================================
    // Filter update; s1 feeds only s2 to keep metastability contained
    always_comb
    begin
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3 && st.s3 != st.out)
        begin
            // Short excursions restart the timer
            if (st.cnt >= HOLD_W)
            begin
                next_st.out = st.s3;
                next_st.cnt = '0;
            end
            else
                next_st.cnt = st.cnt + W'(1);
        end
        else
            next_st.cnt = '0;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT, cnt: '0};
        else
            st <= next_st;
    end

    assign filtered = st.out;

endmodule : level_filter

/* File: logic/totem_pole_drive_steering.sv */
// Drive steering and startup gating for a bridgeless totem-pole converter
`timescale 1ns/100ps
`include "tp_drive_defs.svh"
module totem_pole_drive_steering #(
    parameter int OT_FILTER_CYC = `TP_OT_FILTER_CYC,
    parameter int OV_FILTER_CYC = `TP_OV_FILTER_CYC,
    parameter int OT_BLANK_CYC = `TP_OT_BLANK_CYC,
    parameter int POL_FILTER_CYC = `TP_POL_FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic duty_pulse,
    input wire logic polarity_cmp,
    input wire logic fault_below_ot,
    input wire logic fault_above_ov,
    input wire logic line_undervoltage_flag,
    input wire logic supply_above_on,
    input wire logic supply_above_off,
    input wire logic interval_in_range,
    input wire logic sync_rect_enable,
    input wire logic slow_leg_enable,
    output tp_drive_pkg::drive_t drive,
    output tp_drive_pkg::status_t status
);
    localparam int BW = $clog2(OT_BLANK_CYC + 1) + 1;
    localparam logic [BW-1:0] BLANK_W = BW'(OT_BLANK_CYC);

    typedef struct packed {
        tp_drive_pkg::run_state_t run;
        logic pol_prev;
        logic [2:0] valid_cycle_count;
        logic line_freq_ok;
        logic [BW-1:0] blank_cnt;
        tp_drive_pkg::drive_t drv;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic pol_filt;
    logic ot_filt;
    logic ov_filt;
    logic uv_sync;
    logic on_sync;
    logic off_sync;
    logic range_sync;

    // ==========================================================
    // Pin conditioning: polarity and fault filters
    level_filter #(.HOLD(POL_FILTER_CYC), .INIT(1'b0)) u_pol (
        .clk(clk),
        .rst(rst),
        .raw(polarity_cmp),
        .filtered(pol_filt)
    );
    level_filter #(.HOLD(OT_FILTER_CYC), .INIT(1'b0)) u_ot (
        .clk(clk),
        .rst(rst),
        .raw(fault_below_ot),
        .filtered(ot_filt)
    );
    level_filter #(.HOLD(OV_FILTER_CYC), .INIT(1'b0)) u_ov (
        .clk(clk),
        .rst(rst),
        .raw(fault_above_ov),
        .filtered(ov_filt)
    );

    // Synchronisers with the minimum hold filter (TP_SYNC_HOLD) for the analog status levels
    level_filter #(.HOLD(`TP_SYNC_HOLD), .INIT(1'b1)) u_uv (
        .clk(clk),
        .rst(rst),
        .raw(line_undervoltage_flag),
        .filtered(uv_sync)
    );
    level_filter #(.HOLD(`TP_SYNC_HOLD), .INIT(1'b0)) u_on (
        .clk(clk),
        .rst(rst),
        .raw(supply_above_on),
        .filtered(on_sync)
    );
    level_filter #(.HOLD(`TP_SYNC_HOLD), .INIT(1'b0)) u_off (
        .clk(clk),
        .rst(rst),
        .raw(supply_above_off),
        .filtered(off_sync)
    );
    level_filter #(.HOLD(`TP_SYNC_HOLD), .INIT(1'b0)) u_rng (
        .clk(clk),
        .rst(rst),
        .raw(interval_in_range),
        .filtered(range_sync)
    );

    // ==========================================================
    // Derived conditions
    logic pol_rise;
    logic pol_fall;
    logic pol_edge;
    logic blank_done;
    logic ot_fault;
    logic any_fault;
    logic start_ok;

    assign pol_rise = pol_filt & ~st.pol_prev;
    assign pol_fall = ~pol_filt & st.pol_prev;
    assign pol_edge = pol_rise | pol_fall;
    assign blank_done = (st.blank_cnt >= BLANK_W);
    assign ot_fault = ot_filt & blank_done;
    // Fault gating is level based: drives resume once both filters clear
    assign any_fault = ot_fault | ov_filt;
    // Startup gate; on-level must stay present while armed
    assign start_ok = ~uv_sync & on_sync & st.line_freq_ok;

    // ==========================================================
    // Half-cycle steering decode
    // The duty leg follows the pulse and its partner only conducts in the
    // off-time, so a leg can never be commanded on from both sides at once.
    // Only the slow switch carrying the return current is ever enabled.
    function automatic tp_drive_pkg::drive_t steer_drive(
        input logic positive,
        input logic pulse,
        input logic sync_en,
        input logic slow_en
    );
        tp_drive_pkg::drive_t d;
        d = '0;
        if (positive)
        begin
            d.fast_low_drive = pulse;
            d.fast_high_drive = sync_en & ~pulse;
            d.slow_low_drive = slow_en;
        end
        else
        begin
            d.fast_high_drive = pulse;
            d.fast_low_drive = sync_en & ~pulse;
            d.slow_high_drive = slow_en;
        end
        return d;
    endfunction : steer_drive

    // ==========================================================
    // Sequencer, line validation and drive steering
    always_comb
    begin
        next_st = st;
        next_st.pol_prev = pol_filt;

        // Blanking restarts whenever the supply is below off level
        if (!off_sync)
            next_st.blank_cnt = '0;
        else if (!blank_done)
            next_st.blank_cnt = st.blank_cnt + BW'(1);

        // Consecutive valid toggles; a bad interval restarts counting
        if (pol_edge)
        begin
            if (!range_sync)
            begin
                next_st.valid_cycle_count = '0;
                next_st.line_freq_ok = 1'b0;
            end
            else if (st.valid_cycle_count < `TP_VALID_NEEDED)
            begin
                next_st.valid_cycle_count = st.valid_cycle_count + 3'h1;
                if (st.valid_cycle_count == `TP_VALID_NEEDED - 3'h1)
                    next_st.line_freq_ok = 1'b1;
            end
        end

        case (st.run)
            tp_drive_pkg::ST_IDLE:
            begin
                if (start_ok && off_sync)
                    next_st.run = tp_drive_pkg::ST_ARMED;
            end
            tp_drive_pkg::ST_ARMED:
            begin
                if (!start_ok || !off_sync)
                    next_st.run = tp_drive_pkg::ST_IDLE;
                else if (pol_rise)
                    next_st.run = tp_drive_pkg::ST_RUN;
            end
            tp_drive_pkg::ST_RUN:
            begin
                // Dropping under the on-level alone keeps running
                if (!off_sync || uv_sync)
                    next_st.run = tp_drive_pkg::ST_IDLE;
            end
            default:
                next_st.run = tp_drive_pkg::ST_IDLE;
        endcase

        // Drives default low; costs one dead cycle at each edge
        next_st.drv = '0;
        if (st.run == tp_drive_pkg::ST_RUN && next_st.run ==
            tp_drive_pkg::ST_RUN && !any_fault && !pol_edge)
            next_st.drv = steer_drive(pol_filt, duty_pulse,
                sync_rect_enable, slow_leg_enable);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{run: tp_drive_pkg::ST_IDLE, pol_prev: 1'b0,
                    valid_cycle_count: 3'h0, line_freq_ok: 1'b0,
                    blank_cnt: '0, drv: '0};
        else
            st <= next_st;
    end

    // ==========================================================
    // Outputs
    assign drive = st.drv;
    assign status.running = (st.run == tp_drive_pkg::ST_RUN);
    assign status.over_temp_fault = ot_fault;
    assign status.over_voltage_fault = ov_filt;
    assign status.line_freq_ok = st.line_freq_ok;
    assign status.polarity = pol_filt;

endmodule : totem_pole_drive_steering

/* File: bench/tp_drive_properties.sv */
// Port checker for the drive steering block, bound to its top
`timescale 1ns/100ps
module tp_drive_checker #(
    parameter int OT_FILTER_CYC = 8,
    parameter int OV_FILTER_CYC = 8,
    parameter int OT_BLANK_CYC = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic duty_pulse,
    input wire logic fault_below_ot,
    input wire logic fault_above_ov,
    input wire logic supply_above_off,
    input wire logic sync_rect_enable,
    input wire logic slow_leg_enable,
    input wire tp_drive_pkg::drive_t drive,
    input wire tp_drive_pkg::status_t status
);
    // ==========================================================
    // Helper logic
    int ot_run;
    int ov_run;
    int off_run;
    wire logic calm = status.running && !status.over_temp_fault
        && !status.over_voltage_fault;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Raw run lengths; raw pins lead the synchronised copies
    always_ff @(posedge clk)
    begin
        ot_run <= fault_below_ot ? ot_run + (ot_run < 9999) : 0;
        ov_run <= fault_above_ov ? ov_run + (ov_run < 9999) : 0;
        off_run <= supply_above_off ? off_run + (off_run < 9999) : 0;
    end

    a_fast_excl: assert property (
        !(drive.fast_low_drive && drive.fast_high_drive))
        else $error("fast leg overlap");
    a_slow_excl: assert property (
        !(drive.slow_low_drive && drive.slow_high_drive))
        else $error("slow leg overlap");
    a_pos_steer: assert property (
        calm && $past(calm) && status.polarity && $past(status.polarity, 2)
        |-> drive == {$past(duty_pulse), $past(sync_rect_enable & ~duty_pulse),
        $past(slow_leg_enable), 1'b0}) else $error("positive steering");
    a_neg_steer: assert property (
        calm && $past(calm) && !status.polarity && !$past(status.polarity, 2)
        |-> drive == {$past(sync_rect_enable & ~duty_pulse), $past(duty_pulse),
        1'b0, $past(slow_leg_enable)}) else $error("negative steering");
    a_dead_cycle: assert property (
        $changed(status.polarity) |=> drive == 4'h0)
        else $error("no dead cycle at polarity change");
    a_idle_low: assert property (
        !status.running && !$past(status.running) |-> drive == 4'h0)
        else $error("drive while stopped");
    a_fault_low: assert property (
        $past(status.over_temp_fault || status.over_voltage_fault)
        |-> drive == 4'h0) else $error("drive under fault");
    a_start_edge: assert property (
        $rose(status.running) |-> status.polarity && $past(status.polarity)
        && !$past(status.polarity, 2) && $past(status.line_freq_ok, 2))
        else $error("start off a rising edge");
    a_ov_filter: assert property (
        $rose(status.over_voltage_fault) |-> ov_run > OV_FILTER_CYC)
        else $error("overvoltage flagged early");
    a_ot_filter: assert property (
        $rose(status.over_temp_fault) |-> ot_run > OT_FILTER_CYC
        && off_run >= OT_BLANK_CYC) else $error("over-temp flagged early");

    c_start: cover property ($rose(status.running));
    c_ov: cover property ($rose(status.over_voltage_fault));
    c_ot: cover property ($rose(status.over_temp_fault));
endmodule : tp_drive_checker

bind totem_pole_drive_steering tp_drive_checker #(
    .OT_FILTER_CYC(OT_FILTER_CYC), .OV_FILTER_CYC(OV_FILTER_CYC),
    .OT_BLANK_CYC(OT_BLANK_CYC)
) i_tp_drive_checker (.clk(clk), .rst(rst), .duty_pulse(duty_pulse),
    .fault_below_ot(fault_below_ot), .fault_above_ov(fault_above_ov),
    .supply_above_off(supply_above_off), .drive(drive), .status(status),
    .sync_rect_enable(sync_rect_enable), .slow_leg_enable(slow_leg_enable));

/* File: bench/half_bridge_model.sv */
// Behavioural half-bridge drivers on the far side of the drive outputs
`timescale 1ns/100ps
module half_bridge_model (
    input wire logic clk,
    input wire tp_drive_pkg::drive_t drive,
    output logic shoot_through
);
    // ==========================================================
    // Leg model
    // Sticky, so a one-cycle overlap is never lost between checks
    logic seen = 1'b0;
    always @(posedge clk)
    begin
        if ((drive.fast_low_drive && drive.fast_high_drive)
            || (drive.slow_low_drive && drive.slow_high_drive))
            seen <= 1'b1;
    end
    assign shoot_through = seen;
endmodule : half_bridge_model

/* File: bench/testbench.sv */
// Self-checking bench for the drive steering block
`timescale 1ns/100ps
`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
        end \
    end
module testbench;
    // ==========================================================
    // Stimulus and model
    localparam int OTC = 8;
    localparam int BLK = 50;
    logic clk = 1'b0, rst = 1'b1, duty = 1'b0, pol = 1'b0, ot = 1'b0;
    logic ov = 1'b0, uv = 1'b1, on = 1'b1, off = 1'b1, inr = 1'b1;
    logic sre = 1'b1, sle = 1'b1, shoot;
    tp_drive_pkg::drive_t drive;
    tp_drive_pkg::status_t status;
    int failures = 0, compares = 0, cycles = 0;
    logic [2:0] q[$];

    totem_pole_drive_steering #(.OT_FILTER_CYC(OTC), .OV_FILTER_CYC(8),
        .OT_BLANK_CYC(BLK), .POL_FILTER_CYC(20)) i_totem_pole_drive_steering (
        .clk(clk), .rst(rst), .duty_pulse(duty), .polarity_cmp(pol),
        .fault_below_ot(ot), .fault_above_ov(ov), .line_undervoltage_flag(uv),
        .supply_above_on(on), .supply_above_off(off), .interval_in_range(inr),
        .sync_rect_enable(sre), .slow_leg_enable(sle), .drive(drive),
        .status(status));
    half_bridge_model i_half_bridge_model (.clk(clk), .drive(drive),
        .shoot_through(shoot));

    // Expected drives from last cycle's duty, sync and slow enables
    function automatic tp_drive_pkg::drive_t exp_drive(logic [2:0] v, logic p);
        return p ? {v[2], v[1] & ~v[2], v[0], 1'b0}
            : {v[1] & ~v[2], v[2], 1'b0, v[0]};
    endfunction : exp_drive

    task automatic final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Wait out synchroniser plus filter with a few cycles of margin
    task automatic edge_to(logic v);
        pol = v;
        tick(32);
    endtask : edge_to

    task automatic steer(logic p);
        tp_drive_pkg::drive_t e;
        `CHK(status.polarity, p)
        repeat (30)
        begin
            duty = 1'($urandom);
            sre = 1'($urandom);
            sle = 1'($urandom);
            q.push_back({duty, sre, sle});
            tick(1);
            // Pop once: the macro evaluates its arguments more than once
            e = exp_drive(q.pop_front(), p);
            `CHK(drive, e)
        end
    endtask : steer

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            final_report;
        end
    end

    initial
    begin
        void'($urandom(95));
        tick(5);
        rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            edge_to(~pol);
            `CHK(status.line_freq_ok, logic'(i >= 3))
        end
        `CHK(status.running, 1'b0)
        uv = 1'b0;
        on = 1'b0;
        edge_to(1'b1);
        `CHK(status.running, 1'b0)
        on = 1'b1;
        edge_to(1'b0);
        `CHK(status.running, 1'b0)
        edge_to(1'b1);
        `CHK(status.running, 1'b1)
        steer(1'b1);
        edge_to(1'b0);
        steer(1'b0);
        ov = 1'b1;
        tick(4);
        ov = 1'b0;
        tick(12);
        `CHK(status.over_voltage_fault, 1'b0)
        ov = 1'b1;
        tick(20);
        `CHK(status.over_voltage_fault, 1'b1)
        `CHK(drive, 4'h0)
        ov = 1'b0;
        on = 1'b0;
        tick(20);
        `CHK(status.running, 1'b1)
        off = 1'b0;
        tick(8);
        `CHK(status.running, 1'b0)
        off = 1'b1;
        ot = 1'b1;
        tick(30);
        `CHK(status.over_temp_fault, 1'b0)
        tick(BLK + 10);
        `CHK(status.over_temp_fault, 1'b1)
        ot = 1'b0;
        tick(20);
        ot = 1'b1;
        tick(4);
        ot = 1'b0;
        tick(12);
        `CHK(status.over_temp_fault, 1'b0)
        on = 1'b1;
        edge_to(1'b1);
        `CHK(status.running, 1'b1)
        rst = 1'b1;
        tick(2);
        `CHK(status.running, 1'b0)
        `CHK(drive, 4'h0)
        rst = 1'b0;
        tick(2);
        `CHK(drive, 4'h0)
        `CHK(shoot, 1'b0)
        final_report;
    end
endmodule : testbench
